/* File: dsadc_pkg.sv */
// Shared constants, types and helpers of the converter sequencer and its reader.
// Assumes one 10 MHz system clock and an active-high asynchronous reset.
// Function
// (RULE1) Four modes: single, multi, continuous, turbo
// (RULE2) Start by control write or trigger
// (RULE3) Done high until result is read
// (RULE4) Single: four conversions, first three prime
// (RULE5) Single: back to standby after read
// (RULE6) Continuous: first result after three periods; the code gives the first result at the end of the fourth period
// (RULE7) No input switching in continuous mode
// (RULE8) Multi: reset and re-prime every sample
// (RULE9) Multi: next sample starts automatically
// (RULE10) Turbo: like multi, 20 bits single reset
// (RULE11) Invalid until fourth sample after switch
// (RULE12) Fourth-order sinc decimator, bit to words
// (RULE13) Resolution selects decimation and output rate
// (RULE14) Host polls status or uses done
// (RULE15) Trigger optional, driven by logic
// (RULE16) Done rises after every result
// (RULE17) Trigger synchronised, rising edge only
package dsadc_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 2;
  localparam int RES_W  = 20;
  localparam int ACC_W  = 41;
  localparam int CIC_N  = 4;

  // Device register map on the link
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_STAT   = 2'h1;
  localparam logic [1:0] REG_RESULT = 2'h2;
  localparam int CTRL_START   = 0;
  localparam int CTRL_STOP    = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_RES_LO  = 4;
  localparam int STAT_DONE    = 0;
  localparam int STAT_BUSY    = 1;
  localparam int STAT_WAIT    = 2;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] RES_RESET  = 2'h1;

  // Host register map on the command port
  localparam logic [1:0] HREG_CMD    = 2'h0;
  localparam logic [1:0] HREG_EVT    = 2'h1;
  localparam logic [1:0] HREG_MASK   = 2'h2;
  localparam logic [1:0] HREG_RESULT = 2'h3;
  localparam int EVT_RESULT  = 0;
  localparam int EVT_OVERRUN = 1;
  localparam logic [1:0] EVT_RESET  = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // Timing
  localparam int SYS_CLK_NS    = 100;
  localparam int MOD_PERIOD_NS = 400;
  localparam int MOD_DIV       = (MOD_PERIOD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [1:0] PRIME_PERIODS = 2'h3;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_MULTI  = 2'h1,
    MODE_CONT   = 2'h2,
    MODE_TURBO  = 2'h3
  } dsadc_mode_t;

  typedef enum logic [1:0] {
    RES_8  = 2'h0,
    RES_12 = 2'h1,
    RES_16 = 2'h2,
    RES_20 = 2'h3
  } dsadc_res_t;

  // Decimation ratio is 2**(4+2*res): 16, 64, 256, 1024
  function automatic logic [9:0] dsadc_last_idx(input dsadc_res_t r);
    return 10'((11'h010 << (2 * r)) - 11'h001);
  endfunction

  // Keeps the top bits of the sinc4 output: 4*log2(R) - resolution
  function automatic int dsadc_shift(input dsadc_res_t r);
    return 4 * (4 + 2 * int'(r)) - (8 + 4 * int'(r));
  endfunction

  function automatic logic [RES_W-1:0] dsadc_max(input dsadc_res_t r);
    return 20'hFFFFF >> (12 - 4 * int'(r));
  endfunction
endpackage

/* File: dsadc_link_if.sv */
// Link between the converter sequencer and the result reader.
// Assumes both ends run on the same sys_clk; reset reaches each end directly.
`timescale 1ns/100ps
interface dsadc_link_if
  import dsadc_pkg::*;
(
  input wire logic sys_clk
);
  logic              trigger;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              done;

  modport dev (
    input  trigger,
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata,
    output done
  );

  modport host (
    output trigger,
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata,
    input  done
  );
endinterface

/* File: dsadc_sequencer.sv */
// Delta-sigma sequencer: modulator timing, sinc4 decimator, mode control, registers.
// Assumes the modulator bit is synchronous to sys_clk and valid at each strobe.
`timescale 1ns/100ps
module dsadc_sequencer
  import dsadc_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  reset,
  dsadc_link_if.dev  link,
  input  wire logic  modBit,
  input  wire logic  chanSwitch,
  output logic       modStrobe,
  output logic       modReset,
  output logic       busy
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_CONV = 3'b010,
    S_WAIT = 3'b100
  } dsadc_state_t;

  dsadc_state_t      state_q;
  dsadc_state_t      state_d;
  dsadc_mode_t       mode_q;
  dsadc_res_t        res_q;
  logic              trgS1_q;
  logic              trgS2_q;
  logic              trgS3_q;
  logic [2:0]        modCnt_q;
  logic              modEn_q;
  logic [9:0]        decCnt_q;
  logic [1:0]        primeCnt_q;
  logic [ACC_W-1:0]  integ_q [CIC_N];
  logic [ACC_W-1:0]  combDly_q [CIC_N];
  logic [ACC_W-1:0]  combIn [CIC_N];
  logic [ACC_W-1:0]  combStage;
  logic [ACC_W-1:0]  scaled;
  logic [RES_W-1:0]  resultWord;
  logic [RES_W-1:0]  result_q;
  logic              done_q;
  logic [DATA_W-1:0] rdata_q;
  logic              modRst_q;
  logic              trigRise;
  logic              ctrlWr;
  logic              startReq;
  logic              stopReq;
  logic              resultRead;
  logic              periodEnd;
  logic              publish;
  logic              multiLike;
  logic              turbo20;
  logic              clearConv;

  // Trigger synchroniser and edge detect
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      trgS1_q <= 1'b0;
      trgS2_q <= 1'b0;
      trgS3_q <= 1'b0;
    end else begin
      trgS1_q <= link.trigger; // RULE17
      trgS2_q <= trgS1_q;
      trgS3_q <= trgS2_q;
    end
  end

  assign trigRise   = trgS2_q & ~trgS3_q; // RULE17 RULE15
  assign ctrlWr     = link.wr && link.addr == REG_CTRL;
  assign startReq   = (ctrlWr && link.wdata[CTRL_START]) || trigRise; // RULE2
  assign stopReq    = ctrlWr && link.wdata[CTRL_STOP];
  assign resultRead = link.rd && link.addr == REG_RESULT;
  assign periodEnd  = modEn_q && state_q == S_CONV && decCnt_q == dsadc_last_idx(res_q); // RULE13
  assign publish    = periodEnd && primeCnt_q == PRIME_PERIODS; // RULE4 RULE6 RULE11
  assign multiLike  = mode_q == MODE_MULTI || (mode_q == MODE_TURBO && res_q != RES_20); // RULE10
  assign turbo20    = mode_q == MODE_TURBO && res_q == RES_20; // RULE10
  assign clearConv  = (startReq && state_q != S_WAIT) || (chanSwitch && state_q == S_CONV)
                    || (publish && multiLike); // RULE8 RULE9 RULE11

  // Mode and resolution, writable while stopped
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_q <= dsadc_mode_t'(MODE_RESET);
      res_q  <= dsadc_res_t'(RES_RESET);
    end else if (ctrlWr && state_q == S_IDLE) begin
      mode_q <= dsadc_mode_t'(link.wdata[CTRL_MODE_LO +: 2]); // RULE1
      res_q  <= dsadc_res_t'(link.wdata[CTRL_RES_LO +: 2]); // RULE13
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: begin
        if (startReq) begin
          state_d = S_CONV; // RULE2
        end
      end
      S_CONV: begin
        if (stopReq) begin
          state_d = S_IDLE;
        end else if (publish && mode_q == MODE_SINGLE) begin
          state_d = S_WAIT; // RULE4
        end
      end
      S_WAIT: begin
        if (resultRead || stopReq) begin
          state_d = S_IDLE; // RULE5
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Modulator strobe divider
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      modCnt_q <= 3'h0;
      modEn_q  <= 1'b0;
    end else if (modCnt_q == 3'(MOD_DIV - 1)) begin
      modCnt_q <= 3'h0;
      modEn_q  <= 1'b1;
    end else begin
      modCnt_q <= modCnt_q + 3'h1;
      modEn_q  <= 1'b0;
    end
  end

  // Decimation phase and priming count
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      decCnt_q   <= 10'h000;
      primeCnt_q <= 2'h0;
    end else if (clearConv || state_q != S_CONV) begin
      decCnt_q   <= 10'h000;
      primeCnt_q <= 2'h0; // RULE8 RULE11
    end else if (periodEnd) begin
      decCnt_q <= 10'h000;
      if (primeCnt_q != PRIME_PERIODS) begin
        primeCnt_q <= primeCnt_q + 2'h1; // RULE4 RULE6
      end
    end else if (modEn_q) begin
      decCnt_q <= decCnt_q + 10'h001;
    end
  end

  // Comb section evaluated at the decimation point
  always_comb begin
    combStage = integ_q[CIC_N-1];
    for (int k = 0; k < CIC_N; k++) begin
      combIn[k] = combStage;
      combStage = combStage - combDly_q[k]; // RULE12
    end
    scaled     = combStage >> dsadc_shift(res_q);
    resultWord = (scaled > ACC_W'(dsadc_max(res_q))) ? dsadc_max(res_q) : scaled[RES_W-1:0];
  end

  // Integrators at the modulator rate, comb delays at the output rate
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < CIC_N; k++) begin
        integ_q[k]   <= '0;
        combDly_q[k] <= '0;
      end
    end else if (clearConv || state_q != S_CONV) begin
      for (int k = 0; k < CIC_N; k++) begin
        integ_q[k]   <= '0;
        combDly_q[k] <= '0;
      end
    end else if (modEn_q) begin
      integ_q[0] <= integ_q[0] + ACC_W'(modBit); // RULE12
      for (int k = 1; k < CIC_N; k++) begin
        integ_q[k] <= integ_q[k] + integ_q[k-1];
      end
      if (periodEnd) begin
        // Each comb stage remembers its own input
        for (int k = 0; k < CIC_N; k++) begin
          combDly_q[k] <= combIn[k]; // RULE12
        end
      end
    end
  end

  // Result and done flag; a new result wins over a read
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      result_q <= '0;
      done_q   <= 1'b0;
    end else if (publish) begin
      result_q <= resultWord;
      done_q   <= 1'b1; // RULE3 RULE16
    end else if (resultRead) begin
      done_q <= 1'b0; // RULE3
    end
  end

  // Register reads answer one cycle later
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (link.rd) begin
      unique case (link.addr)
        REG_CTRL:   rdata_q <= DATA_W'({res_q, mode_q, 2'b00});
        REG_STAT:   rdata_q <= DATA_W'({state_q == S_WAIT, state_q != S_IDLE, done_q}); // RULE14
        REG_RESULT: rdata_q <= DATA_W'(result_q);
        default:    rdata_q <= '0;
      endcase
    end
  end

  // Converter reset pulse and status outputs
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      modRst_q <= 1'b1;
      busy     <= 1'b0;
    end else begin
      modRst_q <= clearConv || (turbo20 && publish); // RULE8 RULE10
      busy     <= state_d == S_CONV;
    end
  end

  assign link.rdata = rdata_q;
  assign link.done  = done_q;
  assign modStrobe  = modEn_q;
  assign modReset   = modRst_q;
endmodule

/* File: dsadc_reader.sv */
// Result reader on the far end: forwards commands, drains results, raises an interrupt.
// Assumes software drives the command port with one-cycle strobes on sys_clk.
`timescale 1ns/100ps
module dsadc_reader
  import dsadc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  dsadc_link_if.host             link,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [DATA_W-1:0] cmdWdata,
  input  wire logic              cmdWr,
  input  wire logic              cmdRd,
  output logic      [DATA_W-1:0] cmdRdata,
  input  wire logic              trigReq,
  output logic                   irq
);
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              wr_q;
  logic              rd_q;
  logic              rdWait_q;
  logic              trig_q;
  logic              fwdPend_q;
  logic [DATA_W-1:0] fwdData_q;
  logic [DATA_W-1:0] result_q;
  logic [1:0]        evt_q;
  logic [1:0]        evt_d;
  logic [1:0]        mask_q;
  logic              irq_q;
  logic [DATA_W-1:0] rdOut_q;
  logic              evtWr;

  assign evtWr = cmdWr && cmdAddr == HREG_EVT;

  // Commands queue one link write
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fwdPend_q <= 1'b0;
      fwdData_q <= '0;
    end else if (cmdWr && cmdAddr == HREG_CMD) begin
      fwdPend_q <= 1'b1; // RULE2
      fwdData_q <= cmdWdata;
    end else if (fwdPend_q) begin
      fwdPend_q <= 1'b0;
    end
  end

  // Link master: a pending write first, else read on done
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      addr_q   <= REG_CTRL;
      wdata_q  <= '0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      rdWait_q <= 1'b0;
      trig_q   <= 1'b0;
    end else begin
      wr_q     <= fwdPend_q;
      rd_q     <= !fwdPend_q && link.done && !rd_q && !rdWait_q; // RULE14
      rdWait_q <= rd_q;
      trig_q   <= trigReq; // RULE15
      if (fwdPend_q) begin
        addr_q  <= REG_CTRL;
        wdata_q <= fwdData_q;
      end else begin
        addr_q <= REG_RESULT;
      end
    end
  end

  // Sticky events, write one to clear, a new event wins
  always_comb begin
    evt_d = evt_q;
    if (evtWr) begin
      evt_d = evt_q & ~cmdWdata[1:0];
    end
    if (rdWait_q) begin
      evt_d[EVT_RESULT] = 1'b1;
      if (evt_q[EVT_RESULT]) begin
        evt_d[EVT_OVERRUN] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      evt_q    <= EVT_RESET;
      mask_q   <= MASK_RESET;
      result_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      evt_q <= evt_d;
      if (rdWait_q) begin
        result_q <= link.rdata;
      end
      if (cmdWr && cmdAddr == HREG_MASK) begin
        mask_q <= cmdWdata[1:0];
        irq_q  <= |(evt_d & cmdWdata[1:0]);
      end else begin
        irq_q <= |(evt_d & mask_q);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdOut_q <= '0;
    end else if (cmdRd) begin
      unique case (cmdAddr)
        HREG_CMD:    rdOut_q <= fwdData_q;
        HREG_EVT:    rdOut_q <= DATA_W'(evt_q);
        HREG_MASK:   rdOut_q <= DATA_W'(mask_q);
        HREG_RESULT: rdOut_q <= result_q;
        default:     rdOut_q <= '0;
      endcase
    end
  end

  assign link.addr    = addr_q;
  assign link.wdata   = wdata_q;
  assign link.wr      = wr_q;
  assign link.rd      = rd_q;
  assign link.trigger = trig_q;
  assign cmdRdata     = rdOut_q;
  assign irq          = irq_q;
endmodule

/* File: dsadc_link_asserts.sv */
// Concurrent checks on the link between the sequencer and the reader.
// Assumes it sits beside the link interface, one clock, active-high async reset.
`timescale 1ns/100ps
module dsadc_link_asserts
  import dsadc_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic              trigger,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              done
);
  logic [7:0] sinceDone_q;
  logic       resRd;

  assign resRd = rd && (addr == REG_RESULT);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Cycles since the last result, saturating
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sinceDone_q <= 8'h00;
    end else if ($rose(done)) begin
      sinceDone_q <= 8'h00;
    end else if (sinceDone_q != 8'hFF) begin
      sinceDone_q <= sinceDone_q + 8'h01;
    end
  end

  a_strobe_exclusive: assert property (!(wr && rd)) else $error("wr and rd high together");
  a_done_held: assert property (done && !resRd |=> done) else $error("done fell without a read");
  a_done_clear: assert property ($fell(done) |-> $past(resRd)) else $error("done fell late or early");
  a_drain_result: assert property ($rose(done) |-> ##[1:3] resRd) else $error("result not drained");
  a_write_ctrl: assert property (wr |-> addr == REG_CTRL) else $error("write outside control");
  a_rdata_cause: assert property ($changed(rdata) |-> $past(rd)) else $error("rdata moved without rd");
  a_result_width: assert property ($past(resRd) |-> rdata[DATA_W-1:RES_W] == '0)
    else $error("result bits above width");
  a_result_gap: assert property ($rose(done) |-> sinceDone_q >= 8'h3F)
    else $error("results closer than one period");

  c_result: cover property ($rose(done));
  c_write: cover property (wr);
  c_clear: cover property ($fell(done));
endmodule

/* File: tb_top.sv */
// Testbench: sequencer and reader joined by the link, driven from the command port.
// Assumes a 10 MHz clock; the modulator bit is a constant level set by the single, continuous and turbo scenarios.
`timescale 1ns/100ps
module tb_top
  import dsadc_pkg::*;
;
  logic              sysClk;
  logic              reset;
  logic              modBit;
  logic              chanSwitch;
  logic              cmdWr;
  logic              cmdRd;
  logic              trigReq;
  logic [ADDR_W-1:0] cmdAddr;
  logic [DATA_W-1:0] cmdWdata;
  logic [DATA_W-1:0] cmdRdata;
  logic              modStrobe;
  logic              modReset;
  logic              busy;
  logic              irq;
  int                nErrors;
  int                cmpCount;

  dsadc_link_if u_dsadc_link_if (.sys_clk(sysClk));

  dsadc_sequencer u_dsadc_sequencer (.sys_clk(sysClk), .reset(reset), .link(u_dsadc_link_if),
    .modBit(modBit), .chanSwitch(chanSwitch), .modStrobe(modStrobe), .modReset(modReset), .busy(busy));

  dsadc_reader u_dsadc_reader (.sys_clk(sysClk), .reset(reset), .link(u_dsadc_link_if),
    .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata),
    .trigReq(trigReq), .irq(irq));

  dsadc_link_asserts u_dsadc_link_asserts (.sys_clk(sysClk), .reset(reset),
    .trigger(u_dsadc_link_if.trigger), .addr(u_dsadc_link_if.addr), .wdata(u_dsadc_link_if.wdata),
    .wr(u_dsadc_link_if.wr), .rd(u_dsadc_link_if.rd), .rdata(u_dsadc_link_if.rdata),
    .done(u_dsadc_link_if.done));

  initial begin
    sysClk = 1'h0;
    forever #50 sysClk = ~sysClk;
  end

  task automatic close_out;
    $display("errors %0d comparisons %0d", nErrors, cmpCount);
    if (nErrors == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
    @(posedge sysClk);
    cmdAddr <= a;
    cmdWdata <= d;
    cmdWr <= 1'h1;
    @(posedge sysClk);
    cmdWr <= 1'h0;
  endtask

  task automatic rd_reg(input logic [1:0] a, output logic [31:0] d);
    @(posedge sysClk);
    cmdAddr <= a;
    cmdRd <= 1'h1;
    @(posedge sysClk);
    cmdRd <= 1'h0;
    #1 d = cmdRdata;
  endtask

  function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] r, input logic st, input logic sp);
    return {26'h0, r, m, sp, st};
  endfunction

  // Counts edges up to the next rise of done, and converter resets on the way
  task automatic next_done(input int lim, output int n, output int r);
    logic p;
    n = 0;
    r = 0;
    #1;
    do begin
      p = u_dsadc_link_if.done;
      @(posedge sysClk);
      #1;
      n++;
      r += int'(modReset);
    end while (!(u_dsadc_link_if.done === 1'h1 && p === 1'h0) && n < lim);
    if (n >= lim) begin
      nErrors++;
      $display("ERROR no result within %0d cycles", lim);
    end
  endtask

  task automatic quiet(output int n);
    n = 0;
    repeat (600) begin
      @(posedge sysClk);
      #1 n += int'(u_dsadc_link_if.done !== 1'h0);
    end
  endtask

  task automatic t_single;
    logic [31:0] d;
    int n, r;
    modBit <= 1'h1;
    wr_reg(HREG_MASK, 32'h1);
    wr_reg(HREG_CMD, cw(MODE_SINGLE, RES_8, 1'h1, 1'h0));
    next_done(400, n, r);
    chk("single latency", 32'h1, 32'(n inside {[250:270]}));
    repeat (4) @(posedge sysClk);
    rd_reg(HREG_EVT, d);
    chk("event flag", 32'h1, d);
    chk("irq raised", 32'h1, {31'h0, irq});
    rd_reg(HREG_RESULT, d);
    chk("full scale 8 bit", 32'h0000_00FF, d);
    wr_reg(HREG_EVT, 32'h1);
    @(posedge sysClk);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    quiet(n);
    chk("no restart", 32'h0, 32'(n));
    chk("standby", 32'h0, {31'h0, busy});
    n = 0;
    repeat (64) begin
      @(posedge sysClk);
      #1 n += int'(modStrobe);
    end
    chk("strobe rate", 32'(64 / MOD_DIV), 32'(n));
  endtask

  task automatic t_trigger;
    int n, r;
    wr_reg(HREG_MASK, 32'h0);
    @(posedge sysClk);
    trigReq <= 1'h1;
    next_done(400, n, r);
    chk("trigger latency", 32'h1, 32'(n inside {[250:275]}));
    repeat (4) @(posedge sysClk);
    quiet(n);
    chk("held trigger", 32'h0, 32'(n));
    chk("masked irq", 32'h0, {31'h0, irq});
    wr_reg(HREG_MASK, 32'h1);
    @(posedge sysClk);
    #1 chk("unmasked irq", 32'h1, {31'h0, irq});
    wr_reg(HREG_EVT, 32'h3);
    trigReq <= 1'h0;
  endtask

  task automatic t_cont;
    logic [31:0] d;
    int n, r;
    modBit <= 1'h0;
    wr_reg(HREG_CMD, cw(MODE_CONT, RES_8, 1'h1, 1'h0));
    next_done(400, n, r);
    chk("first after priming", 32'h1, 32'(n inside {[250:270]}));
    next_done(100, n, r);
    chk("continuous period", 32'd64, 32'(n));
    repeat (4) @(posedge sysClk);
    rd_reg(HREG_RESULT, d);
    chk("zero input", 32'h0, d);
    rd_reg(HREG_CMD, d);
    chk("command readback", cw(MODE_CONT, RES_8, 1'h1, 1'h0), d);
    wr_reg(HREG_CMD, cw(MODE_CONT, RES_8, 1'h0, 1'h1));
  endtask

  task automatic t_multi;
    dsadc_mode_t ms[2] = '{MODE_MULTI, MODE_TURBO};
    int n, r;
    foreach (ms[i]) begin
      repeat (4) @(posedge sysClk);
      wr_reg(HREG_CMD, cw(ms[i], RES_8, 1'h1, 1'h0));
      next_done(400, n, r);
      next_done(400, n, r);
      chk("re-primed gap", 32'h1, 32'(n inside {[250:270]}));
      chk("converter reset", 32'h1, 32'(r > 0));
      @(posedge sysClk);
      chanSwitch <= 1'h1;
      @(posedge sysClk);
      chanSwitch <= 1'h0;
      next_done(400, n, r);
      chk("switch reprimes", 32'h1, 32'(n inside {[250:270]}));
      wr_reg(HREG_CMD, cw(ms[i], RES_8, 1'h0, 1'h1));
    end
  endtask

  task automatic t_turbo20;
    logic [31:0] d;
    int n, r;
    modBit <= 1'h1;
    repeat (4) @(posedge sysClk);
    wr_reg(HREG_CMD, cw(MODE_TURBO, RES_20, 1'h1, 1'h0));
    next_done(17000, n, r);
    next_done(5000, n, r);
    chk("turbo period", 32'd4096, 32'(n));
    chk("one reset per result", 32'h1, 32'(r));
    repeat (4) @(posedge sysClk);
    rd_reg(HREG_RESULT, d);
    chk("full scale 20 bit", 32'h000F_FFFF, d);
    wr_reg(HREG_CMD, cw(MODE_TURBO, RES_20, 1'h0, 1'h1));
  endtask

  initial begin
    repeat (40000) @(posedge sysClk);
    nErrors++;
    close_out;
  end

  initial begin
    nErrors = 0;
    cmpCount = 0;
    reset = 1'h1;
    modBit = 1'h0;
    chanSwitch = 1'h0;
    cmdWr = 1'h0;
    cmdRd = 1'h0;
    trigReq = 1'h0;
    cmdAddr = 2'h0;
    cmdWdata = 32'h0;
    repeat (8) @(posedge sysClk);
    reset <= 1'h0;
    t_single;
    t_trigger;
    t_cont;
    t_multi;
    t_turbo20;
    close_out;
  end
endmodule
